// *** rtl/rsr_pkg.sv ***
// constants shared by the radio serial receiver
package rsr_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMD1 = 8'h00;
  localparam logic [7:0] OFS_CMD2 = 8'h04;
  localparam logic [7:0] OFS_CMD3 = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FINE_LSB = 0;
  localparam int COARSE_LSB = 4;
  localparam int RXEN_BIT = 0;
  localparam int TXEN_BIT = 1;
  localparam int CODEC_BIT = 2;
  localparam int LCODE_LSB = 4;
  localparam int START_LSB = 0;
  localparam int ISRC_LSB = 2;
  localparam int EXTCLK_BIT = 5;
  localparam int ST_START = 0;
  localparam int ST_BYTE = 1;
  localparam int ST_FULL = 2;
  localparam int ST_OVR = 3;
  localparam int LEVEL_LSB = 4;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD1_RST = 8'h00;
  localparam logic [7:0] CMD2_RST = 8'h00;
  localparam logic [7:0] CMD3_RST = 8'h00;
  localparam logic [3:0] MASK_RST = 4'h0;
  // ----------------------------------------------------------------
  // codes and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] LC_NRZ_MARK = 3'h1;
  localparam logic [2:0] LC_MANCH_LEVEL = 3'h3;
  localparam logic [1:0] SD_VIOLATION = 2'h1;
  localparam logic [1:0] SD_PATTERN = 2'h2;
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam int FIFO_DEPTH = 4;
endpackage : rsr_pkg

// *** rtl/rsr_fifo.sv ***
// small byte fifo built from flip-flops
`timescale 1ns/10ps
module rsr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW = $clog2(DEPTH)
) (
  // clock and control
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic flush_i,
  // fill side
  input wire logic push_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic full_o,
  // drain side
  input wire logic pop_i,
  output logic [WIDTH-1:0] data_o,
  output logic empty_o,
  output logic [AW:0] level_o
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic do_push;
  logic do_pop;

  assign full_o = (cnt_q == (AW+1)'(DEPTH));
  assign empty_o = (cnt_q == '0);
  assign do_push = push_i && !full_o;
  assign do_pop = pop_i && !empty_o;
  assign data_o = mem_q[rd_q];
  assign level_o = cnt_q;

  always_ff @(posedge clk_i) begin
    if (ce_i && do_push) begin
      mem_q[wr_q] <= data_i;
    end
  end

  // oldest byte leaves first [RULE_15]
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce_i) begin
      if (flush_i) begin
        wr_q <= '0;
        rd_q <= '0;
        cnt_q <= '0;
      end else begin
        if (do_push) wr_q <= AW'(wr_q + 1'b1);
        if (do_pop) rd_q <= AW'(rd_q + 1'b1);
        cnt_q <= (AW+1)'(cnt_q + do_push - do_pop);
      end
    end
  end
endmodule : rsr_fifo

// *** rtl/rsr_top.sv ***
// radio serial receiver with wishbone register slave
// Contract
// [RULE_01] receive only when rx on, tx off
// [RULE_02] baud equals clock over sixteen times factor
// [RULE_03] coarse 00 factor is fine plus one
// [RULE_04] manchester symbols run at twice bit rate
// [RULE_05] select 0 ignores external bit clock
// [RULE_06] codec on: 001 nrz mark, 011 manchester
// [RULE_07] start 10 pattern pin, 01 violation
// [RULE_08] source 001 start irq, 100 full irq
// [RULE_09] four byte fifo, each read pops
// [RULE_10] byte into full fifo dropped, overrun set
// [RULE_11] start detection flushes the receive fifo
// [RULE_12] host services full irq before next byte
// [RULE_13] host ignores data before first start
// [RULE_14] host start, then full, then restore
// [RULE_15] fifo returns bytes oldest first
`timescale 1ns/10ps
module rsr_top (
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // radio link
  input wire logic rx_data_i,
  input wire logic rx_bitclk_i,
  input wire logic rx_pattern_i,
  // interrupt
  output logic irq_o
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------
  logic [7:0] cmd1_q;
  logic [7:0] cmd2_q;
  logic [7:0] cmd3_q;
  logic [3:0] mask_q;
  logic [3:0] status_q;
  logic [3:0] fine;
  logic [1:0] coarse;
  logic active;
  logic codec_en;
  logic [2:0] lcode;
  logic [1:0] start_sel;
  logic [2:0] isrc;
  logic ext_clk_sel;

  assign fine = cmd1_q[rsr_pkg::FINE_LSB +: 4];
  assign coarse = cmd1_q[rsr_pkg::COARSE_LSB +: 2];
  assign active = cmd2_q[rsr_pkg::RXEN_BIT]
                  && !cmd2_q[rsr_pkg::TXEN_BIT]; // [RULE_01]
  assign codec_en = cmd2_q[rsr_pkg::CODEC_BIT];
  assign lcode = cmd2_q[rsr_pkg::LCODE_LSB +: 3];
  assign start_sel = cmd3_q[rsr_pkg::START_LSB +: 2];
  assign isrc = cmd3_q[rsr_pkg::ISRC_LSB +: 3];
  assign ext_clk_sel = cmd3_q[rsr_pkg::EXTCLK_BIT];

  // ----------------------------------------------------------------
  // baud generator
  // ----------------------------------------------------------------
  // coarse steps are powers of four, so 00 leaves fine+1 alone
  logic [10:0] factor;
  logic [10:0] pre_q;
  logic [3:0] ovs_q;
  logic tick;
  logic rx_prev_q;
  logic line_edge;
  logic int_stb;
  logic clk_prev_q;
  logic ext_stb;
  logic sym_stb;
  logic sym_val;

  assign factor = 11'({7'h00, fine} + 11'h001) << {coarse, 1'b0}; // [RULE_03]
  assign tick = (pre_q >= 11'(factor - 11'h001));
  assign line_edge = rx_data_i ^ rx_prev_q;
  // sixteen ticks per symbol [RULE_02]
  assign int_stb = tick && (ovs_q == rsr_pkg::OVS_MID);
  assign ext_stb = rx_bitclk_i && !clk_prev_q;
  // external bit clock only when selected [RULE_05]
  assign sym_stb = active && (ext_clk_sel ? ext_stb : int_stb);
  assign sym_val = rx_data_i;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 11'h000;
      ovs_q <= 4'h0;
      rx_prev_q <= 1'b0;
      clk_prev_q <= 1'b0;
    end else if (ce_i) begin
      rx_prev_q <= rx_data_i;
      clk_prev_q <= rx_bitclk_i;
      pre_q <= tick ? 11'h000 : 11'(pre_q + 11'h001);
      // realign sampling point on every line edge
      if (line_edge) ovs_q <= 4'h0;
      else if (tick) ovs_q <= 4'(ovs_q + 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // line decoder
  // ----------------------------------------------------------------
  // manchester pairs two symbols per bit, so the baud generator
  // must be set to twice the bit rate by software
  logic manch;
  logic nrz_mark;
  logic last_sym_q;
  logic half_q;
  logic first_q;
  logic violation;
  logic bit_stb;
  logic bit_val;

  assign manch = codec_en && (lcode == rsr_pkg::LC_MANCH_LEVEL); // [RULE_06]
  assign nrz_mark = codec_en && (lcode == rsr_pkg::LC_NRZ_MARK); // [RULE_06]
  assign violation = manch && sym_stb && half_q
                     && (first_q == sym_val); // [RULE_04]
  assign bit_stb = manch ? (sym_stb && half_q && !violation) : sym_stb;
  assign bit_val = manch ? first_q
                 : nrz_mark ? (sym_val ^ last_sym_q) : sym_val;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      last_sym_q <= 1'b0;
      half_q <= 1'b0;
      first_q <= 1'b0;
    end else if (ce_i && sym_stb) begin
      last_sym_q <= sym_val;
      // a violation drops pairing so the next symbol starts a bit
      if (!manch || violation) begin
        half_q <= 1'b0;
      end else begin
        half_q <= !half_q;
        if (!half_q) first_q <= sym_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // start detection and byte assembly
  // ----------------------------------------------------------------
  logic pat_prev_q;
  logic start_ev;
  logic [7:0] shift_q;
  logic [2:0] bcnt_q;
  logic byte_done;
  logic [7:0] byte_val;

  assign start_ev = active
    && (((start_sel == rsr_pkg::SD_PATTERN)
         && rx_pattern_i && !pat_prev_q)
     || ((start_sel == rsr_pkg::SD_VIOLATION) && violation)); // [RULE_07]
  assign byte_done = active && bit_stb && !start_ev && (bcnt_q == 3'h7);
  assign byte_val = {shift_q[6:0], bit_val};

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pat_prev_q <= 1'b0;
      shift_q <= 8'h00;
      bcnt_q <= 3'h0;
    end else if (ce_i) begin
      pat_prev_q <= rx_pattern_i;
      if (start_ev || !active) begin
        bcnt_q <= 3'h0;
      end else if (bit_stb) begin
        shift_q <= byte_val;
        bcnt_q <= 3'(bcnt_q + 3'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // receive fifo
  // ----------------------------------------------------------------
  logic fifo_full;
  logic fifo_empty;
  logic [7:0] fifo_data;
  logic [2:0] fifo_level;
  logic fifo_pop;
  logic overrun_ev;
  logic full_prev_q;
  logic full_ev;

  // byte into a full fifo is refused by the fifo [RULE_10]
  assign overrun_ev = byte_done && fifo_full; // [RULE_10]
  assign full_ev = fifo_full && !full_prev_q;

  rsr_fifo #(
    .WIDTH(8),
    .DEPTH(rsr_pkg::FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .clk_i(clock_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .flush_i(start_ev), // [RULE_11]
    .push_i(byte_done), // [RULE_09]
    .data_i(byte_val),
    .full_o(fifo_full),
    .pop_i(fifo_pop),
    .data_o(fifo_data),
    .empty_o(fifo_empty),
    .level_o(fifo_level)
  );

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) full_prev_q <= 1'b0;
    else if (ce_i) full_prev_q <= fifo_full;
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic req;
  logic ack_q;
  logic [31:0] dat_q;
  logic wr_take;
  logic rd_take;
  logic hit_cmd1;
  logic hit_cmd2;
  logic hit_cmd3;
  logic hit_rx;
  logic hit_st;
  logic hit_mask;
  logic [7:0] rd_byte;
  logic [3:0] events;
  logic [3:0] st_clr;
  logic [3:0] src_gate;

  assign req = wb_cyc_i && wb_stb_i;
  assign wr_take = req && wb_we_i && ack_q && wb_sel_i[0];
  assign rd_take = req && !wb_we_i && !ack_q;
  assign hit_cmd1 = (wb_adr_i == rsr_pkg::OFS_CMD1);
  assign hit_cmd2 = (wb_adr_i == rsr_pkg::OFS_CMD2);
  assign hit_cmd3 = (wb_adr_i == rsr_pkg::OFS_CMD3);
  assign hit_rx = (wb_adr_i == rsr_pkg::OFS_RXDATA);
  assign hit_st = (wb_adr_i == rsr_pkg::OFS_STATUS);
  assign hit_mask = (wb_adr_i == rsr_pkg::OFS_MASK);
  // every read of the data register while the fifo is not empty removes one byte [RULE_09]
  assign fifo_pop = rd_take && hit_rx;
  assign rd_byte = hit_cmd1 ? cmd1_q
                 : hit_cmd2 ? cmd2_q
                 : hit_cmd3 ? cmd3_q
                 : hit_rx ? (fifo_empty ? 8'h00 : fifo_data)
                 : hit_st ? {1'b0, fifo_level, status_q}
                 : hit_mask ? {4'h0, mask_q}
                 : 8'h00;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q <= req && !ack_q;
      if (rd_take) dat_q <= {24'h00_0000, rd_byte};
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd1_q <= rsr_pkg::CMD1_RST;
      cmd2_q <= rsr_pkg::CMD2_RST;
      cmd3_q <= rsr_pkg::CMD3_RST;
      mask_q <= rsr_pkg::MASK_RST;
    end else if (ce_i && wr_take) begin
      if (hit_cmd1) cmd1_q <= wb_dat_i[7:0];
      if (hit_cmd2) cmd2_q <= wb_dat_i[7:0];
      if (hit_cmd3) cmd3_q <= wb_dat_i[7:0];
      if (hit_mask) mask_q <= wb_dat_i[3:0];
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  // sticky events; a new event beats a write-one clear
  assign events = {overrun_ev, full_ev, byte_done, start_ev};
  assign st_clr = (wr_take && hit_st) ? wb_dat_i[3:0] : 4'h0;
  // source field picks which of start, byte and full may interrupt; overrun always may [RULE_08]
  assign src_gate = {1'b1, isrc[2], isrc[1], isrc[0]};
  assign irq_o = |(status_q & mask_q & src_gate);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) status_q <= 4'h0;
    else if (ce_i) status_q <= (status_q & ~st_clr) | events; // [RULE_10]
  end
endmodule : rsr_top

// *** bench/rsr_top_assertions.sv ***
// port-level checks for the radio serial receiver
`timescale 1ns/10ps
module rsr_top_checker (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // link and interrupt
  input wire logic rx_data_i,
  input wire logic rx_bitclk_i,
  input wire logic rx_pattern_i,
  input wire logic irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  logic [3:0] mask_q;
  logic rx_on_q;
  wire wr_w = wb_ack_o && wb_we_i && wb_sel_i[0];
  wire rd_w = wb_ack_o && !wb_we_i;
  wire map_w = wb_adr_i <= rsr_pkg::OFS_MASK && wb_adr_i[1:0] == 2'h0;
  // mirrors of mask and link enable, written where ack is seen
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mask_q <= rsr_pkg::MASK_RST;
      rx_on_q <= 1'b0;
    end else if (wr_w && wb_adr_i == rsr_pkg::OFS_MASK) begin
      mask_q <= wb_dat_i[3:0];
    end else if (wr_w && wb_adr_i == rsr_pkg::OFS_CMD2) begin
      rx_on_q <= wb_dat_i[0] && !wb_dat_i[1];
    end
  end
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_ack_pulse: assert property (req_s |=> pulse_s)
    else $error("ack not a single pulse after request");
  chk_ack_cause: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_read_upper: assert property (
    rd_w |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_unmapped_zero: assert property (
    rd_w && !map_w |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_level_bound: assert property (
    rd_w && wb_adr_i == rsr_pkg::OFS_STATUS |-> wb_dat_o[6:4] <= 3'h4)
    else $error("fifo level above depth");
  chk_irq_masked: assert property (mask_q == 4'h0 |-> !irq_o)
    else $error("irq with all sources masked");
  chk_rx_off_quiet: assert property (
    !rx_on_q && !$past(wr_w) |-> !$rose(irq_o))
    else $error("irq rose while receiver off");
  chk_data_held: assert property (
    $changed(wb_dat_o) |-> rd_w)
    else $error("read data changed outside a read");
endmodule : rsr_top_checker

bind rsr_top rsr_top_checker u_rsr_top_checker (.clock_i(clock_i),
  .reset_n_i(reset_n_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rx_data_i(rx_data_i), .rx_bitclk_i(rx_bitclk_i),
  .rx_pattern_i(rx_pattern_i), .irq_o(irq_o));

// *** bench/rsr_radio_model.sv ***
// behavioural transceiver sending nrz mark symbols
`timescale 1ns/10ps
module rsr_radio_model (
  // link to receiver
  input wire logic clock_i,
  output logic data_o,
  output logic bitclk_o,
  output logic pattern_o
);
  int per = 16;
  initial begin
    data_o = 1'b0;
    bitclk_o = 1'b0;
    pattern_o = 1'b0;
  end
  // a one toggles the line; bit clock runs but should be ignored
  task automatic sym(input logic b);
    data_o <= data_o ^ b;
    bitclk_o <= ~bitclk_o;
    repeat (per) @(posedge clock_i);
  endtask : sym
  // edge aligns the sampler, pattern comes after its sample point
  task automatic frame(input logic [7:0] q[$]);
    data_o <= ~data_o;
    repeat (per * 3 / 4) @(posedge clock_i);
    pattern_o <= 1'b1;
    repeat (2) @(posedge clock_i);
    pattern_o <= 1'b0;
    repeat (per / 4 - 2) @(posedge clock_i);
    foreach (q[i]) for (int k = 7; k >= 0; k--) sym(q[i][k]);
  endtask : frame
endmodule : rsr_radio_model

// *** bench/radio_serial_receiver_tb.sv ***
// self-checking bench for the radio serial receiver
`timescale 1ns/10ps
module radio_serial_receiver_tb;
  logic clock_i;
  logic reset_n_i;
  logic req, we, ack, irq, rxd, bclk, pat;
  logic [7:0] adr;
  logic [31:0] wd, rdat, rd;
  logic [7:0] exp[$];
  logic [3:0] st = 4'h0;
  logic [3:0] msk = 4'h0;
  logic [2:0] src = 3'h0;
  int errors = 0;
  int check_count = 0;
  rsr_top u_rsr_top (.clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_data_i(rxd), .rx_bitclk_i(bclk), .rx_pattern_i(pat), .irq_o(irq));
  rsr_radio_model u_rsr_radio_model (.clock_i(clock_i), .data_o(rxd),
    .bitclk_o(bclk), .pattern_o(pat));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // one classic cycle; ack is read before the edge updates land
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    req <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge clock_i);
    while (ack !== 1'b1 && n < 20) begin
      n++;
      @(posedge clock_i);
    end
    if (n == 20) errors++;
    rd = rdat;
    req <= 1'b0;
    @(posedge clock_i);
  endtask : wb
  task automatic irqc();
    chk("irq", 32'(irq), 32'(|(st & msk & {1'b1, src})));
  endtask : irqc
  task automatic stchk();
    wb(1'b0, rsr_pkg::OFS_STATUS, 32'h0);
    chk("status", rd, {25'h0, 3'(exp.size()), st});
  endtask : stchk
  task automatic drain();
    while (exp.size() > 0) begin
      wb(1'b0, rsr_pkg::OFS_RXDATA, 32'h0);
      chk("rxdata", rd, {24'h0, exp.pop_front()});
    end
    wb(1'b0, rsr_pkg::OFS_RXDATA, 32'h0);
    chk("empty", rd, 32'h0);
  endtask : drain
  // reference fifo: start flushes, full drops and flags
  task automatic frame(input int nb, input bit on, input bit lvl = 1'b0);
    logic [7:0] q[$];
    logic [7:0] b;
    logic [7:0] e;
    logic l;
    l = ~u_rsr_radio_model.data_o;
    if (on) exp = {};
    if (on) st |= 4'h1;
    repeat (nb) begin
      b = 8'($urandom);
      q.push_back(b);
      // level decoding sees the line itself, not its toggles
      for (int k = 7; k >= 0; k--) begin
        l = l ^ b[k];
        e[k] = l;
      end
      if (!lvl) e = b;
      if (on) st |= 4'h2;
      if (on && exp.size() == 4) st |= 4'h8;
      else if (on) exp.push_back(e);
      if (on && exp.size() == 4 && st[3] == 1'b0) st |= 4'h4;
    end
    u_rsr_radio_model.frame(q);
  endtask : frame
  task automatic run(input int nb, input bit on, input logic [7:0] c2);
    wb(1'b1, rsr_pkg::OFS_CMD2, {24'h0, c2});
    frame(nb, on);
    wb(1'b1, rsr_pkg::OFS_CMD2, 32'h14);
  endtask : run
  task automatic clr();
    wb(1'b1, rsr_pkg::OFS_STATUS, 32'hF);
    st = 4'h0;
  endtask : clr
  initial begin
    logic [7:0] regs[5] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h40};
    reset_n_i = 1'b0;
    req = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    wd = 32'h0;
    void'($urandom(28726));
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    foreach (regs[i]) begin
      wb(1'b0, regs[i], 32'h0);
      chk("reset", rd, 32'h0);
    end
    wb(1'b1, rsr_pkg::OFS_MASK, 32'hF);
    msk = 4'hF;
    wb(1'b1, rsr_pkg::OFS_CMD3, 32'h06);
    src = 3'h1;
    run(4, 1, 8'h15);
    irqc();
    stchk();
    clr();
    irqc();
    wb(1'b1, rsr_pkg::OFS_CMD3, 32'h12);
    src = 3'h4;
    drain();
    run(5, 1, 8'h15);
    irqc();
    stchk();
    drain();
    wb(1'b1, rsr_pkg::OFS_MASK, 32'h0);
    msk = 4'h0;
    irqc();
    wb(1'b1, rsr_pkg::OFS_MASK, 32'hF);
    msk = 4'hF;
    clr();
    wb(1'b1, rsr_pkg::OFS_CMD2, 32'h15);
    frame(2, 1);
    run(1, 1, 8'h15);
    stchk();
    drain();
    clr();
    // codec off leaves plain level decoding
    wb(1'b1, rsr_pkg::OFS_CMD2, 32'h11);
    frame(2, 1, 1'b1);
    wb(1'b1, rsr_pkg::OFS_CMD2, 32'h14);
    stchk();
    drain();
    wb(1'b1, rsr_pkg::OFS_CMD1, 32'h0C);
    u_rsr_radio_model.per = 16 * 13;
    run(2, 1, 8'h15);
    drain();
    wb(1'b1, rsr_pkg::OFS_CMD1, 32'h0);
    u_rsr_radio_model.per = 16;
    run(2, 0, 8'h17);
    stchk();
    clr();
    wb(1'b1, rsr_pkg::OFS_CMD3, 32'h05);
    src = 3'h1;
    irqc();
    // steady line gives equal manchester halves
    wb(1'b1, rsr_pkg::OFS_CMD2, 32'h35);
    repeat (160) @(posedge clock_i);
    wb(1'b1, rsr_pkg::OFS_CMD2, 32'h34);
    st = 4'h1;
    irqc();
    wb(1'b0, rsr_pkg::OFS_STATUS, 32'h0);
    chk("violation", 32'(rd[0]), 32'h1);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    summarize();
  end
endmodule : radio_serial_receiver_tb
